// >>> core/msfc_bitser.sv
// Serialiser that shifts one coded block out bit by bit
`timescale 1ns/1ps
module msfc_bitser #(
  parameter int MAXB = 244,
  parameter int LW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire logic [MAXB-1:0] block,
  input wire logic [LW-1:0] len,
  output logic busy,
  output logic bit_valid,
  input wire logic bit_ready,
  output logic bit_data,
  output logic bit_last
);
  logic [MAXB-1:0] sh_reg;
  logic [LW-1:0] left_reg;

  assign busy = left_reg != '0;
  assign bit_valid = busy;
  assign bit_data = sh_reg[MAXB-1];
  assign bit_last = left_reg == LW'(1);

  // Load a block, then shift MSB first on each accepted bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_reg <= '0;
      left_reg <= '0;
    end
    else if (ce)
    begin
      if (load && !busy)
      begin
        sh_reg <= block;
        left_reg <= len;
      end
      else if (busy && bit_ready)
      begin
        sh_reg <= {sh_reg[MAXB-2:0], 1'b0};
        left_reg <= left_reg - 1'b1;
      end
    end
  end
endmodule

// >>> core/msfc_fifo.sv
// Parameterised valid/ready FIFO for sample words
`timescale 1ns/1ps
module msfc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // Honest full and empty from the fill count
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  assign out_data = mem[rd_reg];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (int'(wr_reg) == DEPTH - 1) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (int'(rd_reg) == DEPTH - 1) ? '0 : rd_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// >>> core/msfc_pkg.sv
// Shared constants for the multirate speech frame codec
package msfc_pkg;
  localparam int SAMPLE_W = 13;
  localparam int FRAME_LEN = 160;
  localparam int SUBFRAME_LEN = 40;
  localparam int SUBFRAMES = 4;
  localparam int WINDOW_LEN = 240;
  localparam int LOOKAHEAD_MS = 5;
  localparam int SAMPLE_RATE = 8000;
  localparam int LOOKAHEAD_LEN = LOOKAHEAD_MS * SAMPLE_RATE / 1000;
  localparam int FRAME_MS = 20;
  localparam int CLK_HZ = 125000000;
  // Clock cycles per sample period, longest time rounded down
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE;
  localparam int MAX_BLOCK = 244;
  localparam int MODE_W = 3;
  localparam int LEN_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int LAG_W = 11;
  localparam logic [LEN_W-1:0] LEN_M0 = 8'h5F; // 95 bits
  localparam logic [LEN_W-1:0] LEN_M1 = 8'h67; // 103
  localparam logic [LEN_W-1:0] LEN_M2 = 8'h76; // 118
  localparam logic [LEN_W-1:0] LEN_M3 = 8'h86; // 134
  localparam logic [LEN_W-1:0] LEN_M4 = 8'h94; // 148
  localparam logic [LEN_W-1:0] LEN_M5 = 8'h9F; // 159
  localparam logic [LEN_W-1:0] LEN_M6 = 8'hCC; // 204
  localparam logic [LEN_W-1:0] LEN_M7 = 8'hF4; // 244
  localparam logic [MODE_W-1:0] MODE_TOP = 3'h7; // 12.2 kbit/s
endpackage

// >>> core/msfc_top.sv
// Frame framework of the multirate speech frame codec
`timescale 1ns/1ps
module msfc_top #(
  parameter int SAMPLE_CYC = msfc_pkg::SAMPLE_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [2:0] MODE,
  input wire logic PCM_VALID,
  output logic PCM_READY,
  input wire logic [12:0] PCM_DATA,
  output logic ENC_VALID,
  input wire logic ENC_READY,
  output logic ENC_BIT,
  output logic ENC_LAST,
  output logic [2:0] ENC_MODE,
  output logic LP_SETS,
  output logic [1:0] SUBFRAME,
  output logic OPEN_LOOP,
  output logic CLOSED_LOOP,
  output logic FRAC_SIXTH,
  input wire logic DEC_VALID,
  output logic DEC_READY,
  input wire logic DEC_BIT,
  input wire logic DEC_LAST,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [12:0] OUT_DATA,
  output logic OUT_LAST,
  output logic DEC_ERR
);
  localparam int SW = msfc_pkg::SAMPLE_W;
  localparam int MB = msfc_pkg::MAX_BLOCK;
  localparam int LW = msfc_pkg::LEN_W;
  localparam int TW = $clog2(SAMPLE_CYC + 1);

  typedef enum logic [1:0] {MSFC_FILL, MSFC_EMIT, MSFC_WAIT} msfc_enc_e;
  typedef enum logic [1:0] {MSFC_RX, MSFC_PLAY, MSFC_DONE} msfc_dec_e;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Block length for each rate mode
  function automatic logic [LW-1:0] mode_len(input logic [2:0] m);
    case (m)
      3'h0: mode_len = msfc_pkg::LEN_M0;
      3'h1: mode_len = msfc_pkg::LEN_M1;
      3'h2: mode_len = msfc_pkg::LEN_M2;
      3'h3: mode_len = msfc_pkg::LEN_M3;
      3'h4: mode_len = msfc_pkg::LEN_M4;
      3'h5: mode_len = msfc_pkg::LEN_M5;
      3'h6: mode_len = msfc_pkg::LEN_M6;
      default: mode_len = msfc_pkg::LEN_M7;
    endcase
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Input FIFO in the PCM path
  logic fifo_valid;
  logic fifo_ready;
  logic [SW-1:0] fifo_data;
  logic fifo_in_ready;
  msfc_fifo #(.WIDTH(SW), .DEPTH(msfc_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    .in_valid(PCM_VALID),
    .in_ready(fifo_in_ready),
    .in_data(PCM_DATA),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );
  // Offer space only while the clock enable lets a sample land
  assign PCM_READY = CE && fifo_in_ready;

  // Encoder state
  msfc_enc_e enc_reg;
  logic [7:0] in_cnt_reg;
  logic [2:0] mode_reg;
  logic [7:0] need_reg;
  logic [MB-1:0] acc_reg;
  logic ser_busy;
  logic ser_valid;
  logic ser_load;
  logic [MB-1:0] ser_block;

  // Samples needed before analysis: frame plus lookahead except top mode
  assign need_reg = (mode_reg == msfc_pkg::MODE_TOP) ?
    8'(msfc_pkg::FRAME_LEN) :
    8'(msfc_pkg::FRAME_LEN + msfc_pkg::LOOKAHEAD_LEN);
  assign fifo_ready = CE && (enc_reg == MSFC_FILL);
  assign ser_load = (enc_reg == MSFC_EMIT);
  // Left-justify the block so the serialiser sends MSB first
  assign ser_block = acc_reg << (MB - int'(mode_len(mode_reg)));

  // First difference on each popped sample as a high-pass stage
  logic [SW-1:0] prev_reg;
  logic [SW-1:0] hp_val;
  assign hp_val = fifo_data - prev_reg;
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= '0;
    else if (CE && fifo_valid && fifo_ready)
      prev_reg <= fifo_data;
  end

  // Samples held for the analysis window, saturating at its length
  logic [7:0] win_reg;
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
      win_reg <= '0;
    else if (CE && fifo_valid && fifo_ready &&
      win_reg != 8'(msfc_pkg::WINDOW_LEN))
      win_reg <= win_reg + 8'h01;
  end

  // Frame collection, one block per frame
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enc_reg <= MSFC_FILL;
      in_cnt_reg <= '0;
      mode_reg <= '0;
      acc_reg <= '0;
    end
    else if (CE)
    begin
      case (enc_reg)
        MSFC_FILL:
        begin
          if (in_cnt_reg == 8'h00)
            mode_reg <= MODE;
          if (fifo_valid)
          begin
            acc_reg <= {acc_reg[MB-SW-1:0], hp_val}
              ^ {{(MB-SW){1'b0}}, acc_reg[MB-1:MB-SW]};
            if (in_cnt_reg == 8'(msfc_pkg::FRAME_LEN - 1))
            begin
              in_cnt_reg <= '0;
              enc_reg <= MSFC_EMIT;
            end
            else
              in_cnt_reg <= in_cnt_reg + 8'h01;
          end
        end
        MSFC_EMIT:
          if (!ser_busy)
            enc_reg <= MSFC_WAIT;
        default:
          if (!ser_busy)
          begin
            enc_reg <= MSFC_FILL;
            acc_reg <= '0;
          end
      endcase
    end
  end

  // Subframe cadence over the 160 collected samples
  logic [5:0] sub_cnt_reg;
  logic [1:0] sub_reg;
  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_cnt_reg <= '0;
      sub_reg <= '0;
    end
    else if (CE && fifo_valid && fifo_ready)
    begin
      if (sub_cnt_reg == 6'(msfc_pkg::SUBFRAME_LEN - 1))
      begin
        sub_cnt_reg <= '0;
        sub_reg <= sub_reg + 2'h1;
      end
      else
        sub_cnt_reg <= sub_cnt_reg + 6'h01;
    end
  end
  assign SUBFRAME = sub_reg;
  // Closed-loop search each subframe, open-loop every second one
  assign CLOSED_LOOP = fifo_valid && fifo_ready && sub_cnt_reg == '0;
  assign OPEN_LOOP = CLOSED_LOOP && !sub_reg[0];
  assign LP_SETS = mode_reg == msfc_pkg::MODE_TOP;
  assign FRAC_SIXTH = mode_reg == msfc_pkg::MODE_TOP;
  assign ENC_MODE = mode_reg;

  // Bit serialiser for the coded block
  msfc_bitser #(.MAXB(MB), .LW(LW)) u_ser (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .ce(CE),
    .load(ser_load),
    .block(ser_block),
    .len(mode_len(mode_reg)),
    .busy(ser_busy),
    .bit_valid(ser_valid),
    .bit_ready(ENC_READY),
    .bit_data(ENC_BIT),
    .bit_last(ENC_LAST)
  );
  // Offer a bit only while the clock enable lets it be taken
  assign ENC_VALID = CE && ser_valid;

  // Decoder: collect bits, then pace 160 samples at the sample rate
  msfc_dec_e dec_reg;
  logic [LW-1:0] bit_cnt_reg;
  logic [SW-1:0] dsh_reg;
  logic [7:0] out_cnt_reg;
  logic [TW-1:0] tick_reg;
  logic [SW-1:0] out_reg;
  logic err_reg;
  logic len_ok;
  logic [SW-1:0] post_val;

  // Length check against the eight legal block sizes
  always_comb
  begin
    len_ok = 1'b0;
    for (int i = 0; i < 8; i++)
      if (bit_cnt_reg + LW'(1) == mode_len(3'(i)))
        len_ok = 1'b1;
  end

  // Sparse pulse on every fifth position, spread by the last output
  logic [SW-1:0] pulse_val;
  logic [SW-1:0] spread_val;
  assign pulse_val = ((out_cnt_reg % 8'h05) == 8'h00) ? dsh_reg : '0;
  assign spread_val = pulse_val | {2'b00, out_reg[SW-1:2]};

  // Formant stage then tilt stage on the state word
  assign post_val = (spread_val ^ {out_reg[SW-2:0], 1'b0})
    - {1'b0, out_reg[SW-1:1]};

  assign DEC_READY = CE && dec_reg == MSFC_RX;

  always_ff @(posedge CLK_SYS or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dec_reg <= MSFC_RX;
      bit_cnt_reg <= '0;
      dsh_reg <= '0;
      out_cnt_reg <= '0;
      tick_reg <= '0;
      out_reg <= '0;
      err_reg <= 1'b0;
    end
    else if (CE)
    begin
      case (dec_reg)
        MSFC_RX:
          if (DEC_VALID)
          begin
            dsh_reg <= {dsh_reg[SW-2:0], DEC_BIT};
            if (DEC_LAST)
            begin
              err_reg <= !len_ok;
              bit_cnt_reg <= '0;
              dec_reg <= MSFC_PLAY;
            end
            else if (bit_cnt_reg != LW'(MB))
              bit_cnt_reg <= bit_cnt_reg + LW'(1);
          end
        MSFC_PLAY:
          if (OUT_VALID && OUT_READY)
          begin
            out_reg <= post_val;
            tick_reg <= TW'(SAMPLE_CYC - 1);
            if (out_cnt_reg == 8'(msfc_pkg::FRAME_LEN - 1))
            begin
              out_cnt_reg <= '0;
              dec_reg <= MSFC_DONE;
            end
            else
              out_cnt_reg <= out_cnt_reg + 8'h01;
          end
          else if (tick_reg != '0)
            tick_reg <= tick_reg - TW'(1);
        default:
          dec_reg <= MSFC_RX;
      endcase
    end
  end

  assign OUT_VALID = CE && dec_reg == MSFC_PLAY && tick_reg == '0;
  assign OUT_DATA = out_reg;
  assign OUT_LAST = OUT_VALID &&
    out_cnt_reg == 8'(msfc_pkg::FRAME_LEN - 1);
  assign DEC_ERR = err_reg;

  // Checks next to the logic
  a_frame_emit: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && enc_reg == MSFC_FILL && fifo_valid &&
     in_cnt_reg == 8'(msfc_pkg::FRAME_LEN - 1)) |=> enc_reg == MSFC_EMIT)
    else $error("frame did not close after 160 samples");
  a_block_len: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && ser_load && !ser_busy) |=> u_ser.left_reg == mode_len(mode_reg))
    else $error("block length does not match mode");
  a_dec_count: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    OUT_LAST && OUT_READY && CE |=> dec_reg == MSFC_DONE)
    else $error("decoder frame did not end at 160");
  a_out_pace: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && OUT_VALID && OUT_READY && !OUT_LAST) |=> !OUT_VALID)
    else $error("samples faster than sample rate");
  a_sub_wrap: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    sub_cnt_reg <= 6'(msfc_pkg::SUBFRAME_LEN - 1))
    else $error("subframe counter overran");
  a_lp_sets: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (CE && enc_reg == MSFC_FILL && in_cnt_reg == 8'h00) |=>
    LP_SETS == ($past(MODE) == msfc_pkg::MODE_TOP))
    else $error("coefficient set count wrong for mode");
  a_look_need: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (mode_reg != msfc_pkg::MODE_TOP) |->
    need_reg == 8'(msfc_pkg::FRAME_LEN + msfc_pkg::LOOKAHEAD_LEN))
    else $error("lookahead missing");
  a_open_loop: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    OPEN_LOOP |-> CLOSED_LOOP && !SUBFRAME[0])
    else $error("open-loop estimate in odd subframe");
  a_out_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (OUT_VALID && !OUT_READY) |=> $stable(OUT_DATA))
    else $error("sample changed while waiting");
  a_bit_hold: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    (ser_busy && !(CE && ENC_READY)) |=> $stable(ENC_BIT))
    else $error("coded bit changed while waiting");
  a_win_fill: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
    enc_reg == MSFC_EMIT |-> win_reg >= 8'(msfc_pkg::FRAME_LEN))
    else $error("analysis window short at frame close");
endmodule

// >>> test/msfc_partner.sv
// Behavioural PCM source and coded bit sink for the codec
`timescale 1ns/1ps
module msfc_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic slow,
  output logic pcm_valid,
  input wire logic pcm_ready,
  output logic [12:0] pcm_data,
  input wire logic enc_valid,
  output logic enc_ready,
  input wire logic enc_last,
  output logic blk_done,
  output logic [7:0] blk_len
);
  int left;
  int nbits;
  int seed = 58;
  logic took;
  logic start;
  // Sample handshake and frame request at the sampling edge
  always @(posedge clk)
  begin
    took <= pcm_valid && pcm_ready;
    start <= go;
  end
  // Frames of random samples, each held until taken
  always @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left = 0;
      pcm_valid = 1'b0;
      pcm_data = 13'h0000;
      enc_ready = 1'b0;
    end
    else
    begin
      if (took)
        left = left - 1;
      if (start && left == 0)
        left = 160;
      pcm_valid = (left != 0);
      // Idle data line flips so a stale value is never trusted
      if (took || !pcm_valid)
        pcm_data = pcm_valid ? 13'($random(seed)) : ~pcm_data;
      enc_ready = slow ? 1'($random(seed)) : 1'b1;
    end
  end
  // Count coded bits of each block
  always @(posedge clk)
  begin
    blk_done <= 1'b0;
    if (!rst_n)
      nbits = 0;
    else if (enc_valid && enc_ready)
    begin
      nbits = nbits + 1;
      if (enc_last)
      begin
        blk_len <= 8'(nbits);
        blk_done <= 1'b1;
        nbits = 0;
      end
    end
  end
endmodule

// >>> test/tb_msfc_top.sv
// Self-checking bench for the codec frame framework
`timescale 1ns/1ps
module tb_msfc_top;
  localparam int SC = 4;
  localparam logic [7:0] LEN [8] = '{8'h5F, 8'h67, 8'h76, 8'h86,
    8'h94, 8'h9F, 8'hCC, 8'hF4};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode = 3'h0;
  logic go = 1'b0;
  logic slow = 1'b0;
  logic dec_valid = 1'b0;
  logic dec_bit = 1'b0;
  logic dec_last = 1'b0;
  logic out_ready = 1'b0;
  logic ce = 1'b1;
  logic pcm_valid, pcm_ready, enc_valid, enc_ready, enc_last;
  logic lp_sets, open_loop, closed_loop, frac_sixth, dec_ready;
  logic out_valid, out_last, dec_err, blk_done;
  logic [12:0] pcm_data;
  logic [2:0] enc_mode;
  logic [1:0] subframe;
  logic [7:0] blk_len;
  logic [10:0] enc_q[$];
  logic dec_q[$];
  logic [10:0] note;
  int seed = 58;
  int bad_count = 0;
  int checks_done = 0;
  int cl_n = 0;
  int ol_n = 0;
  int out_n = 0;

  always #4 clk_sys = ~clk_sys;

  msfc_top #(.SAMPLE_CYC(SC)) i_msfc_top (.CLK_SYS(clk_sys),
    .RST_N(rst_n), .CE(ce), .MODE(mode), .PCM_VALID(pcm_valid),
    .PCM_READY(pcm_ready), .PCM_DATA(pcm_data), .ENC_VALID(enc_valid),
    .ENC_READY(enc_ready), .ENC_BIT(), .ENC_LAST(enc_last),
    .ENC_MODE(enc_mode), .LP_SETS(lp_sets), .SUBFRAME(subframe),
    .OPEN_LOOP(open_loop), .CLOSED_LOOP(closed_loop),
    .FRAC_SIXTH(frac_sixth), .DEC_VALID(dec_valid),
    .DEC_READY(dec_ready), .DEC_BIT(dec_bit), .DEC_LAST(dec_last),
    .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_DATA(),
    .OUT_LAST(out_last), .DEC_ERR(dec_err));

  msfc_partner i_msfc_partner (.clk(clk_sys), .rst_n(rst_n), .go(go),
    .slow(slow), .pcm_valid(pcm_valid), .pcm_ready(pcm_ready),
    .pcm_data(pcm_data), .enc_valid(enc_valid), .enc_ready(enc_ready),
    .enc_last(enc_last), .blk_done(blk_done), .blk_len(blk_len));

  // Compare one result with its note
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what,
        got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watch outputs and retire the oldest note per result
  always @(posedge clk_sys)
  begin
    if (closed_loop === 1'b1)
    begin
      chk(8'(subframe), 8'(cl_n), "subframe index");
      cl_n++;
    end
    if (open_loop === 1'b1)
      ol_n++;
    if (blk_done === 1'b1)
    begin
      note = enc_q.pop_front();
      chk(blk_len, note[7:0], "block length");
      chk(8'(enc_mode), 8'(note[10:8]), "frame mode");
      chk(8'(lp_sets), 8'(note[10:8] == 3'h7), "coef sets");
      chk(8'(frac_sixth), 8'(note[10:8] == 3'h7), "lag step");
      chk(8'(cl_n), 8'h04, "closed-loop count");
      chk(8'(ol_n), 8'h02, "open-loop count");
      cl_n = 0;
      ol_n = 0;
    end
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      out_n++;
      if (out_last === 1'b1)
      begin
        chk(8'(out_n), 8'hA0, "samples per block");
        chk(8'(dec_err), 8'(dec_q.pop_front()), "length flag");
        out_n = 0;
      end
    end
  end

  // Sink stalls and clock-enable gaps at random
  always @(negedge clk_sys)
  begin
    out_ready <= 1'($random(seed));
    ce <= ($random(seed) & 7) != 0;
  end

  // One frame in every rate mode, slow sink on odd modes
  task automatic enc_seq;
    for (int m = 0; m < 8; m++)
    begin
      mode = 3'(m);
      slow = m[0];
      enc_q.push_back({mode, LEN[m]});
      @(negedge clk_sys);
      go = 1'b1;
      @(negedge clk_sys);
      go = 1'b0;
      @(posedge blk_done);
      @(negedge clk_sys);
    end
    $display("encoder test done");
  endtask

  // Send one coded block, bit held until taken
  task automatic send_blk(input int n, input logic err);
    dec_q.push_back(err);
    for (int i = 0; i < n; i++)
    begin
      dec_valid = 1'b1;
      dec_bit = 1'($random(seed));
      dec_last = (i == n - 1);
      @(posedge clk_sys);
      while (dec_ready !== 1'b1)
        @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask

  // Blocks back to back, an illegal length among them
  task automatic dec_seq;
    for (int m = 0; m < 8; m++)
      send_blk(int'(LEN[m]), 1'b0);
    send_blk(100, 1'b1);
    send_blk(95, 1'b0);
    dec_valid = 1'b0;
    dec_bit = ~dec_bit;
    dec_last = 1'b0;
    while (dec_q.size() != 0)
      @(negedge clk_sys);
    $display("decoder test done");
  endtask

  // Reset, then both directions at once
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    fork
      enc_seq();
      dec_seq();
    join
    repeat (10) @(negedge clk_sys);
    results();
  end

  // Cut a hang short
  initial
  begin
    #(80000 * 8);
    bad_count++;
    $display("wrong value at %0t: run timed out", $time);
    results();
  end
endmodule
